//--- rtl/bir_consts.vh
// register offsets, field positions, reset values, line numbers and clock rate
// assumes inclusion by the block and by its bench
`ifndef BIR_CONSTS_VH
`define BIR_CONSTS_VH
`define BIR_CLK_HZ 25000000
`define BIR_ADDR_W 6
`define BIR_OFF_ELSEL 6'h00
`define BIR_OFF_ROUTE0 6'h04
`define BIR_OFF_ROUTE1 6'h08
`define BIR_OFF_ROUTE2 6'h0C
`define BIR_OFF_ROUTE3 6'h10
`define BIR_OFF_PEND 6'h14
`define BIR_OFF_VECT 6'h18
`define BIR_OFF_EXTIN 6'h1C
`define BIR_OFF_ACK 6'h20
`define BIR_ELSEL_RST 16'h0000
`define BIR_RAW_IDLE 32'h03FFFFFF
`define BIR_FIXED_MASK 16'h2107
`define BIR_ROUTE_EN_BIT 7
`define BIR_ROUTE_RST 8'h00
`define BIR_VECT_VALID_BIT 4
`define BIR_CASCADE_LINE 2
`define BIR_TIMER_LINE 0
`define BIR_UART_LINE 4
`define BIR_ABORT_LINE 8
`define BIR_MON_LINE 5
`endif

//--- rtl/bir_top.v
// board interrupt routing: external controller inputs and legacy pair
// assumes raw board pins are asynchronous; avalon master on clk_in
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "bir_consts.vh"

module bir_top #(
	parameter NUM_EXT = 16,
	parameter NUM_CPU = 2
) (
	input wire clk_in,
	input wire rst_in,
	input wire clk_en_in,
	input wire [`BIR_ADDR_W-1:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	output reg [31:0] avs_readdata_out,
	output reg avs_waitrequest_out,
	input wire timer0_tick_in,
	input wire net_irq_n_in,
	input wire watchdog1_irq_n_in,
	input wire watchdog2_irq_n_in,
	input wire [3:0] vme_bridge_local_irq_n_in,
	input wire [3:0] slot1_irq_n_in,
	input wire [3:0] slot2_irq_n_in,
	input wire [3:0] exp_irq_n_in,
	input wire [1:0] location_monitor_signal_n_in,
	input wire abort_sw_n_in,
	input wire uart_irq_in,
	input wire [3:0] pci_irq_n_in,
	input wire wdog_fitted_in,
	output reg [NUM_EXT-1:0] mp_ext_irq_out,
	output reg legacy_irq_out,
	output reg [NUM_CPU-1:0] cpu_irq_out
);

	// internal sources: two cross-cpu, four timers
	localparam NUM_INT = 6;
	localparam RAW_W = 32;

	reg [RAW_W-1:0] s1, s2, s3, filt;
	wire [RAW_W-1:0] raw;
	reg [15:0] edge_level_select;
	reg [7:0] route [0:3];
	reg [15:0] edge_pend;
	reg [15:0] prev_line;
	reg [NUM_INT-1:0] int_src;
	reg [NUM_CPU*NUM_INT-1:0] int_dest;
	reg [15:0] next_line;
	reg [15:0] pend;
	reg [4:0] vect;
	reg [NUM_EXT-1:0] next_ext;
	integer i;
	integer j;
	integer n;
	genvar g;
	// per-route line masks and next values of the bus side
	wire [15:0] route_hit [0:3];
	wire [NUM_CPU-1:0] next_cpu;
	reg [31:0] next_rdata;
	wire [15:0] line_rise;
	wire [15:0] ack_clr;
	wire rd_go;

	assign raw = {4'h0, timer0_tick_in, uart_irq_in, abort_sw_n_in,
		location_monitor_signal_n_in, pci_irq_n_in, exp_irq_n_in,
		slot2_irq_n_in, slot1_irq_n_in, vme_bridge_local_irq_n_in,
		watchdog2_irq_n_in, watchdog1_irq_n_in, net_irq_n_in};

	// an input change counts once the 2nd and 3rd stages agree
	always @(posedge clk_in) begin
		if (rst_in) begin
			// every stage resets to its pin's idle level, so the
			// active-high timer and uart inputs see no false edge
			s1 <= `BIR_RAW_IDLE;
			s2 <= `BIR_RAW_IDLE;
			s3 <= `BIR_RAW_IDLE;
			filt <= `BIR_RAW_IDLE;
		end else if (clk_en_in) begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			// a one-cycle glitch never reaches filt
			for (i = 0; i < RAW_W; i = i + 1) begin
				if (s2[i] == s3[i]) begin
					filt[i] <= s3[i];
				end
			end
		end
	end

	wire net_a = ~filt[0];
	wire wd1_a = ~filt[1];
	wire wd2_a = ~filt[2];
	wire [3:0] vme_a = ~filt[6:3];
	wire [3:0] sl1_a = ~filt[10:7];
	wire [3:0] sl2_a = ~filt[14:11];
	wire [3:0] exp_a = ~filt[18:15];
	wire [3:0] pci_a = ~filt[22:19];
	wire [1:0] mon_a = ~filt[24:23];
	wire abort_a = ~filt[25];
	wire uart_a = filt[26];
	wire tmr_a = filt[27];

	// decode one route register onto a line mask
	function [15:0] route_mask;
		input [7:0] r;
		begin
			route_mask = 16'h0000;
			if (r[`BIR_ROUTE_EN_BIT])
				route_mask[r[3:0]] = 1'b1;
			route_mask = route_mask & ~`BIR_FIXED_MASK;
		end
	endfunction

	// lowest-numbered set bit wins within a group
	function [4:0] first_set;
		input [7:0] v;
		input [3:0] base;
		integer k;
		begin
			first_set = 5'h00;
			for (k = 7; k >= 0; k = k - 1)
				if (v[k])
					first_set = {1'b1, base + k[3:0]};
		end
	endfunction

	// one masked target per pci input; a disabled route or a
	// reserved target yields no line at all
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_route
			assign route_hit[g] = pci_a[g] ? route_mask(route[g]) :
				16'h0000;
		end
	endgenerate

	reg [15:0] routed;
	reg [15:0] eff_level;
	reg [4:0] pv, sv;
	always @* begin
		// shared line, routes simply or together
		routed = route_hit[0] | route_hit[1] | route_hit[2] |
			route_hit[3];
		next_line = routed;
		next_line[`BIR_TIMER_LINE] = tmr_a;
		next_line[`BIR_UART_LINE] = next_line[`BIR_UART_LINE] | uart_a;
		next_line[`BIR_ABORT_LINE] = abort_a;
		next_line[`BIR_MON_LINE] = next_line[`BIR_MON_LINE] | (|mon_a);
		eff_level = edge_level_select & ~`BIR_FIXED_MASK;
		pend = (next_line & eff_level) | (edge_pend & ~eff_level);
		pend[`BIR_CASCADE_LINE] = |pend[15:8];
		pv = first_set({6'h00, pend[1:0]}, 4'h0);
		sv = first_set(pend[15:8], 4'h8);
		if (pv[4])
			vect = pv;
		else if (sv[4])
			vect = sv;
		else
			vect = first_set({3'h0, pend[7:3]}, 4'h3);
	end

	always @* begin
		next_ext = {NUM_EXT{1'b0}};
		next_ext[0] = |pend;
		next_ext[2] = net_a;
		next_ext[3] = wd1_a & wdog_fitted_in;
		next_ext[4] = wd2_a & wdog_fitted_in;
		next_ext[8:5] = vme_a;
		for (j = 0; j < 4; j = j + 1)
			next_ext[9+j] = sl1_a[j] | sl2_a[(j+1)%4] | exp_a[j];
		next_ext[14:13] = mon_a;
	end

	generate
		for (g = 0; g < NUM_CPU; g = g + 1) begin : g_cpu
			assign next_cpu[g] = (|next_ext) |
				(|(int_src & int_dest[g*NUM_INT +: NUM_INT]));
		end
	endgenerate

	wire acc = avs_read_in | avs_write_in;
	// a write lands on the edge where the master sees waitrequest low,
	// never on the taking edge, so both sides agree on the commit
	wire wr_go = avs_write_in & ~avs_waitrequest_out & clk_en_in;
	// read data is fetched on the taking edge and then stands
	assign rd_go = avs_read_in & avs_waitrequest_out;
	assign ack_clr = (wr_go && avs_address_in == `BIR_OFF_ACK) ?
		avs_writedata_in[15:0] : 16'h0000;
	assign line_rise = next_line & ~prev_line;

	// readback; unmapped and write-only offsets read as zero
	always @* begin
		next_rdata = 32'h00000000;
		case (avs_address_in)
		`BIR_OFF_ELSEL:
			next_rdata = {16'h0000,
				edge_level_select & ~`BIR_FIXED_MASK};
		`BIR_OFF_ROUTE0: next_rdata = {24'h000000, route[0]};
		`BIR_OFF_ROUTE1: next_rdata = {24'h000000, route[1]};
		`BIR_OFF_ROUTE2: next_rdata = {24'h000000, route[2]};
		`BIR_OFF_ROUTE3: next_rdata = {24'h000000, route[3]};
		`BIR_OFF_PEND: next_rdata = {16'h0000, pend};
		`BIR_OFF_VECT: next_rdata = {27'h0000000, vect};
		`BIR_OFF_EXTIN:
			next_rdata = {4'h0, int_dest, 10'h000, int_src};
		default: next_rdata = 32'h00000000;
		endcase
	end

	// interrupt state and pin-facing outputs
	always @(posedge clk_in) begin
		if (rst_in) begin
			edge_pend <= 16'h0000;
			prev_line <= 16'h0000;
			mp_ext_irq_out <= {NUM_EXT{1'b0}};
			legacy_irq_out <= 1'b0;
			cpu_irq_out <= {NUM_CPU{1'b0}};
		end else if (clk_en_in) begin
			prev_line <= next_line;
			edge_pend <= (edge_pend & ~ack_clr) | line_rise;
			mp_ext_irq_out <= next_ext;
			legacy_irq_out <= |pend;
			cpu_irq_out <= next_cpu;
		end
	end

	// register bus side
	always @(posedge clk_in) begin
		if (rst_in) begin
			edge_level_select <= `BIR_ELSEL_RST;
			for (n = 0; n < 4; n = n + 1)
				route[n] <= `BIR_ROUTE_RST;
			int_src <= {NUM_INT{1'b0}};
			int_dest <= {NUM_CPU*NUM_INT{1'b0}};
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h00000000;
		end else if (clk_en_in) begin
			// one wait cycle, then a single answering cycle
			avs_waitrequest_out <= ~(acc & avs_waitrequest_out);
			if (wr_go) begin
				case (avs_address_in)
				`BIR_OFF_ELSEL:
					edge_level_select <= avs_writedata_in[15:0];
				`BIR_OFF_ROUTE0: route[0] <= avs_writedata_in[7:0];
				`BIR_OFF_ROUTE1: route[1] <= avs_writedata_in[7:0];
				`BIR_OFF_ROUTE2: route[2] <= avs_writedata_in[7:0];
				`BIR_OFF_ROUTE3: route[3] <= avs_writedata_in[7:0];
				`BIR_OFF_EXTIN: begin
					int_src <= avs_writedata_in[NUM_INT-1:0];
					int_dest <= avs_writedata_in[16 +:
						NUM_CPU*NUM_INT];
				end
				default: ;
				endcase
			end
			// readdata holds until the next read is taken
			if (rd_go) begin
				avs_readdata_out <= next_rdata;
			end
		end
	end

endmodule // bir_top

//--- verif/bir_src_model.sv
// board interrupt sources facing bir_top pins
// assumes the bench calls its tasks or sets levels from clk_in edges
`timescale 1ns/1ps
module bir_src_model (
	input wire clk_in,
	output logic tick_out,
	output logic uart_out,
	output logic net_n_out,
	output logic wd1_n_out,
	output logic wd2_n_out,
	output logic [3:0] vme_n_out,
	output logic [3:0] s1_n_out,
	output logic [3:0] s2_n_out,
	output logic [3:0] exp_n_out,
	output logic [3:0] pci_n_out,
	output logic [1:0] lm_n_out,
	output logic abort_n_out
);
	// active low sources idle high at rest, the tick and uart outputs idle low
	initial begin
		{tick_out, uart_out} = 2'h0;
		{net_n_out, wd1_n_out, wd2_n_out, abort_n_out} = 4'hF;
		{vme_n_out, s1_n_out, s2_n_out, exp_n_out, pci_n_out} = 20'hFFFFF;
		lm_n_out = 2'h3;
	end
	// timer edge, held three cycles to pass the synchroniser
	task tick;
		@(posedge clk_in) tick_out <= 1'b1;
		repeat (3) @(posedge clk_in);
		tick_out <= 1'b0;
	endtask
endmodule // bir_src_model

//--- verif/bir_top_asserts.sv
// checker for bir_top port timing and external input mapping
// assumes clk_en_in held high and sync active high reset
`timescale 1ns/1ps
module bir_top_asserts #(
	parameter NUM_EXT = 16,
	parameter NUM_CPU = 2
) (
	input wire clk_in,
	input wire rst_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire avs_waitrequest_out,
	input wire net_irq_n_in,
	input wire watchdog1_irq_n_in,
	input wire wdog_fitted_in,
	input wire [3:0] vme_bridge_local_irq_n_in,
	input wire [3:0] slot2_irq_n_in,
	input wire [NUM_EXT-1:0] mp_ext_irq_out,
	input wire legacy_irq_out,
	input wire [NUM_CPU-1:0] cpu_irq_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	wire req = avs_read_in || avs_write_in;
	// eight cycles of low cover the pin synchroniser with margin
	property p_rst;
		disable iff (1'b0) rst_in |=> avs_waitrequest_out && !legacy_irq_out
			&& mp_ext_irq_out == 0 && cpu_irq_out == 0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_ans;
		req && avs_waitrequest_out |=> !avs_waitrequest_out;
	endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_one;
		!avs_waitrequest_out |=> avs_waitrequest_out;
	endproperty
	a_one: assert property (p_one) else $error("answer too long");
	property p_idle;
		!req |=> avs_waitrequest_out;
	endproperty
	a_idle: assert property (p_idle) else $error("answer w/o request");
	property p_unused;
		!mp_ext_irq_out[1] && !mp_ext_irq_out[15];
	endproperty
	a_unused: assert property (p_unused) else $error("unused input set");
	property p_net;
		!net_irq_n_in [*8] |-> mp_ext_irq_out[2] ##[0:2] cpu_irq_out != 0;
	endproperty
	a_net: assert property (p_net) else $error("net not delivered");
	property p_net_off;
		net_irq_n_in [*8] |-> !mp_ext_irq_out[2];
	endproperty
	a_net_off: assert property (p_net_off) else $error("net stuck");
	property p_wdog;
		(wdog_fitted_in && !watchdog1_irq_n_in) [*8] |-> mp_ext_irq_out[3];
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog lost");
	property p_vme;
		!vme_bridge_local_irq_n_in[0] [*8] |-> mp_ext_irq_out[5];
	endproperty
	a_vme: assert property (p_vme) else $error("bridge out lost");
	property p_rot;
		!slot2_irq_n_in[1] [*8] |-> mp_ext_irq_out[9];
	endproperty
	a_rot: assert property (p_rot) else $error("slot rotation");
	property p_leg;
		$rose(legacy_irq_out) |-> ##[0:3] mp_ext_irq_out[0];
	endproperty
	a_leg: assert property (p_leg) else $error("legacy not on 0");
	c_leg: cover property ($rose(legacy_irq_out));
	c_wr: cover property (avs_write_in && !avs_waitrequest_out);
	c_net: cover property ($rose(mp_ext_irq_out[2]));
endmodule // bir_top_asserts

//--- verif/tb_board_interrupt_routing.sv
// bench for bir_top: avalon register tests and pin to output checks
// assumes bir_consts.vh on the include path
`timescale 1ns/1ps
`include "bir_consts.vh"
module tb_board_interrupt_routing;
	logic clk_in = 0, rst_in = 1, rd = 0, wrr = 0, fit = 1;
	logic [5:0] adr = 0;
	logic [31:0] wd = 0, q;
	wire [31:0] rdat;
	wire wt, leg, tk, ua, nt, w1, w2, ab;
	wire [3:0] vm, s1, s2, ex, pc;
	wire [1:0] lm;
	wire [15:0] mx;
	wire [1:0] cpu;
	int fail_count = 0, compares = 0, cyc = 0, i;
	initial forever #20 clk_in = ~clk_in;
	bir_src_model u_src (.clk_in(clk_in), .tick_out(tk), .uart_out(ua),
		.net_n_out(nt), .wd1_n_out(w1), .wd2_n_out(w2), .vme_n_out(vm),
		.s1_n_out(s1), .s2_n_out(s2), .exp_n_out(ex), .pci_n_out(pc),
		.lm_n_out(lm), .abort_n_out(ab));
	bir_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wrr),
		.avs_writedata_in(wd), .avs_readdata_out(rdat),
		.avs_waitrequest_out(wt), .timer0_tick_in(tk), .net_irq_n_in(nt),
		.watchdog1_irq_n_in(w1), .watchdog2_irq_n_in(w2),
		.vme_bridge_local_irq_n_in(vm), .slot1_irq_n_in(s1),
		.slot2_irq_n_in(s2), .exp_irq_n_in(ex),
		.location_monitor_signal_n_in(lm), .abort_sw_n_in(ab),
		.uart_irq_in(ua), .pci_irq_n_in(pc), .wdog_fitted_in(fit),
		.mp_ext_irq_out(mx), .legacy_irq_out(leg), .cpu_irq_out(cpu));
	task conclude;
		$display("checks %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// a hung handshake ends here instead of running forever
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fail_count++;
			conclude;
		end
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_in) {rd, wrr, adr, wd} <= {~w, w, a, d};
		do @(posedge clk_in); while (wt !== 1'b0);
		q = rdat;
		{rd, wrr} <= 2'b00;
	endtask
	task rchk(input string n, input logic [5:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk(n, q, e);
	endtask
	task settle;
		repeat (10) @(posedge clk_in);
	endtask
	initial begin
		repeat (6) @(posedge clk_in);
		rst_in <= 0;
		rchk("elsel", `BIR_OFF_ELSEL, 0);
		rchk("unmapped", 6'h3C, 0);
		bus(1, `BIR_OFF_ELSEL, 32'hFFFF);
		rchk("fixed", `BIR_OFF_ELSEL, 32'hDEF8);
		// bench is software with the controller unused
		bus(1, `BIR_OFF_ELSEL, 32'h8C00);
		bus(1, `BIR_OFF_ROUTE0, 32'h8A);
		bus(1, `BIR_OFF_ROUTE1, 32'h8A);
		bus(1, `BIR_OFF_ROUTE2, 32'h8D);
		bus(1, `BIR_OFF_ROUTE3, 32'h8F);
		for (i = 0; i < 4; i++) begin
			@(posedge clk_in) u_src.pci_n_out[i] <= 1'b0;
			settle;
			bus(0, `BIR_OFF_PEND, 0);
			chk("route", q & 32'hFFFB, i == 3 ? 32'h8000 : i == 2 ? 0 : 32'h400);
			@(posedge clk_in) u_src.pci_n_out[i] <= 1'b1;
			settle;
			rchk("level", `BIR_OFF_PEND, 0);
		end
		@(posedge clk_in) {u_src.uart_out, u_src.pci_n_out} <= 5'h1D;
		settle;
		rchk("prio", `BIR_OFF_VECT, 32'h1A);
		@(posedge clk_in) {u_src.uart_out, u_src.pci_n_out} <= 5'h0F;
		settle;
		rchk("edge", `BIR_OFF_VECT, 32'h14);
		bus(1, `BIR_OFF_ACK, 32'h10);
		rchk("ack", `BIR_OFF_PEND, 0);
		u_src.tick;
		settle;
		rchk("timer", `BIR_OFF_VECT, 32'h10);
		chk("ext0", mx[0], 1);
		chk("legacy", leg, 1);
		bus(1, `BIR_OFF_ACK, 32'h1);
		@(posedge clk_in) u_src.abort_n_out <= 1'b0;
		settle;
		rchk("abort", `BIR_OFF_VECT, 32'h18);
		rchk("cascade", `BIR_OFF_PEND, 32'h104);
		@(posedge clk_in) {u_src.abort_n_out, u_src.lm_n_out} <= 3'b110;
		bus(1, `BIR_OFF_ACK, 32'h100);
		settle;
		chk("mon", mx[14:13], 2'h1);
		rchk("mon5", `BIR_OFF_PEND, 32'h20);
		@(posedge clk_in) {fit, u_src.wd1_n_out} <= 2'b00;
		settle;
		chk("unfitted", mx[3], 0);
		@(posedge clk_in) {fit, u_src.net_n_out} <= 2'b10;
		settle;
		chk("fitted", mx[3], 1);
		chk("net", mx[2], 1);
		chk("cpu", cpu, 2'h3);
		conclude;
	end
endmodule // tb_board_interrupt_routing
bind bir_top bir_top_asserts #(.NUM_EXT(NUM_EXT), .NUM_CPU(NUM_CPU)) u_chk (
	.clk_in(clk_in), .rst_in(rst_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
	.net_irq_n_in(net_irq_n_in), .watchdog1_irq_n_in(watchdog1_irq_n_in),
	.wdog_fitted_in(wdog_fitted_in),
	.vme_bridge_local_irq_n_in(vme_bridge_local_irq_n_in),
	.slot2_irq_n_in(slot2_irq_n_in), .mp_ext_irq_out(mp_ext_irq_out),
	.legacy_irq_out(legacy_irq_out), .cpu_irq_out(cpu_irq_out));
